//--- hw/dspwm_pkg.sv
/*
  dspwm_pkg: constants for the dual-slope frequency-correct pwm block.
  assumes: apb register slave, 32-bit data, one aligned word per register.
*/
package dspwm_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;  // timer_output_wave_control_a
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;  // timer_control_b
  localparam logic [7:0] ADDR_CMP_A = 8'h08;  // compare_value_a buffer
  localparam logic [7:0] ADDR_CMP_B = 8'h0C;  // compare_value_b buffer
  localparam logic [7:0] ADDR_CAP_TOP = 8'h10;  // capture_top_value
  localparam logic [7:0] ADDR_COUNT = 8'h14;  // counter_value, read only
  localparam logic [7:0] ADDR_FLAGS = 8'h18;  // flags, write one to clear
  localparam logic [7:0] ADDR_PINDIR = 8'h1C;  // pin_direction_bit a/b
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // control register a field positions
  localparam int OMS_A_HI = 7;
  localparam int OMS_A_LO = 6;
  localparam int OMS_B_HI = 5;
  localparam int OMS_B_LO = 4;
  localparam int WS_LO_HI = 1;
  localparam int WS_LO_LO = 0;
  // control register b field positions
  localparam int WS_HI_HI = 4;
  localparam int WS_HI_LO = 3;
  localparam int CS_HI = 2;
  localparam int CS_LO = 0;
  // flag bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FLAG_CAP = 3;
  localparam int FLAG_W = 4;
  // waveform modes handled here
  localparam logic [3:0] WS_PFC_CAP = 4'h8;
  localparam logic [3:0] WS_PFC_CMPA = 4'h9;
  localparam logic [3:0] WS_DUAL_MAX = 4'hB;
  // output mode encodings
  localparam logic [1:0] OMS_OFF = 2'h0;
  localparam logic [1:0] OMS_TOGGLE = 2'h1;
  localparam logic [1:0] OMS_NONINV = 2'h2;
  localparam logic [1:0] OMS_INV = 2'h3;
  localparam logic [15:0] BOTTOM = 16'h0000;
  // prescaler selections and divide ratios minus one
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int PRE_W = 10;
  localparam logic [9:0] DIV8_M1 = 10'h007;
  localparam logic [9:0] DIV64_M1 = 10'h03F;
  localparam logic [9:0] DIV256_M1 = 10'h0FF;
  localparam logic [9:0] DIV1024_M1 = 10'h3FF;
  localparam logic [9:0] PRE_ZERO = 10'h000;
  // counter direction states, gray coded
  typedef enum logic [0:0] {
    DSPWM_UP = 1'b0,
    DSPWM_DOWN = 1'b1
  } dspwm_dir_t;
endpackage

//--- hw/dspwm_prescale.sv
/*
  dspwm_prescale: divides clk_sys into a one-cycle timer tick enable.
  assumes: sel changes only from register logic on the same clock.
*/
`timescale 1ns/1ps
module dspwm_prescale (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [9:0] count;  // free running cycle counter
  logic [9:0] limit;  // divide ratio minus one
  logic active;  // a divide ratio is selected
  logic wrap;  // counter at its limit

  // ratio lookup, continuous selection
  assign limit = (sel == dspwm_pkg::CS_DIV8) ? dspwm_pkg::DIV8_M1 :
    (sel == dspwm_pkg::CS_DIV64) ? dspwm_pkg::DIV64_M1 :
    (sel == dspwm_pkg::CS_DIV256) ? dspwm_pkg::DIV256_M1 :
    (sel == dspwm_pkg::CS_DIV1024) ? dspwm_pkg::DIV1024_M1 :
    dspwm_pkg::PRE_ZERO;
  assign active = (sel >= dspwm_pkg::CS_DIV1) &&
    (sel <= dspwm_pkg::CS_DIV1024);
  assign wrap = (count >= limit);
  // tick is a clock enable, never a clock
  assign tick = active && wrap;

  // counter restarts when stopped so the first tick is a full period late
  always_ff @(posedge clk_sys) begin
    if (srst || !active || wrap) begin
      count <= dspwm_pkg::PRE_ZERO;
    end else begin
      count <= count + 10'h001;
    end
  end
endmodule

//--- hw/dspwm_core.sv
/*
  dspwm_core: 16-bit dual-slope timer with double-buffered compares,
  apb register slave and two wave outputs.
  assumes: apb master on clk_sys; load pins take pin_out and pin_oe.
  software keeps top at three or more and at or above both compares;
  the block does not check either, it only stops matching.
*/
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module dspwm_core (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic timer_tick
);
  logic [7:0] ctrl_a;  // timer_output_wave_control_a
  logic [7:0] ctrl_b;  // timer_control_b
  logic [15:0] buf_a;  // compare a buffer
  logic [15:0] buf_b;  // compare b buffer
  logic [15:0] cmp_a;  // active compare_value_a
  logic [15:0] cmp_b;  // active compare b
  logic [15:0] cap_top;  // capture_top_value
  logic [15:0] counter_value;  // the timer
  logic [3:0] flags;  // sticky event flags
  logic [1:0] pin_dir;  // pin_direction_bit per channel
  logic [1:0] wave;  // wave_output per channel
  dspwm_pkg::dspwm_dir_t dir;  // slope state
  dspwm_pkg::dspwm_dir_t next_dir;
  logic [15:0] next_count;

  // bus decode, no wait states; decodes below are named wires except the
  // register write address compares, which the clocked process makes itself
  logic wr;
  logic rd_hit;
  logic [3:0] ws;  // waveform_select
  logic [1:0] oms_a;
  logic [1:0] oms_b;
  logic mode_pfc;
  logic mode_dual;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic tick_top;
  logic tick_bottom;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;  // single-cycle access phase
  assign rd_hit = (paddr == dspwm_pkg::ADDR_CTRL_A) ||
    (paddr == dspwm_pkg::ADDR_CTRL_B) || (paddr == dspwm_pkg::ADDR_CMP_A) ||
    (paddr == dspwm_pkg::ADDR_CMP_B) || (paddr == dspwm_pkg::ADDR_CAP_TOP) ||
    (paddr == dspwm_pkg::ADDR_COUNT) || (paddr == dspwm_pkg::ADDR_FLAGS) ||
    (paddr == dspwm_pkg::ADDR_PINDIR);
  // unmapped addresses answer with an error and change nothing
  // writes there are dropped by the register decode below as well
  assign pslverr = psel && penable && !rd_hit;

  // upper mode bits live in control b
  assign ws = {ctrl_b[dspwm_pkg::WS_HI_HI:dspwm_pkg::WS_HI_LO],
    ctrl_a[dspwm_pkg::WS_LO_HI:dspwm_pkg::WS_LO_LO]};
  assign oms_a = ctrl_a[dspwm_pkg::OMS_A_HI:dspwm_pkg::OMS_A_LO];
  assign oms_b = ctrl_a[dspwm_pkg::OMS_B_HI:dspwm_pkg::OMS_B_LO];
  // only modes 8 and 9 run the counter here
  assign mode_pfc = (ws == dspwm_pkg::WS_PFC_CAP) ||
    (ws == dspwm_pkg::WS_PFC_CMPA);
  assign mode_dual = (ws >= dspwm_pkg::WS_PFC_CAP) &&
    (ws <= dspwm_pkg::WS_DUAL_MAX);
  // top source select top below three is software's concern
  // mode 9 reads the active compare, so a new top waits for bottom
  assign top = (ws == dspwm_pkg::WS_PFC_CMPA) ? cmp_a : cap_top;
  assign at_top = (counter_value == top);
  assign at_bottom = (counter_value == dspwm_pkg::BOTTOM);
  // equality with active compares a top below a compare
  // simply never matches
  assign match_a = (counter_value == cmp_a);
  assign match_b = (counter_value == cmp_b);
  assign tick_top = timer_tick && mode_pfc && at_top;
  assign tick_bottom = timer_tick && mode_pfc && at_bottom &&
    (dir == dspwm_pkg::DSPWM_DOWN);

  // flag events: overflow at bottom compares on match capture at top in mode 8
  assign flag_set[dspwm_pkg::FLAG_OVF] = tick_bottom;
  assign flag_set[dspwm_pkg::FLAG_CMP_A] = timer_tick && mode_pfc && match_a;
  assign flag_set[dspwm_pkg::FLAG_CMP_B] = timer_tick && mode_pfc && match_b;
  assign flag_set[dspwm_pkg::FLAG_CAP] = tick_top &&
    (ws == dspwm_pkg::WS_PFC_CAP);
  assign flag_clr = (wr && paddr == dspwm_pkg::ADDR_FLAGS) ?
    pwdata[dspwm_pkg::FLAG_W-1:0] : 4'h0;

  // prescaled tick enable
  // a stopped prescaler holds every tick-driven register still
  dspwm_prescale u_prescale (
    .clk_sys(clk_sys),
    .srst(srst),
    .sel(ctrl_b[dspwm_pkg::CS_HI:dspwm_pkg::CS_LO]),
    .tick(timer_tick)
  );

  // slope walk: up to top, one tick at top, down to bottom
  // giving a period of two times top ticks
  // a top set below the count on the rising slope lets it run on and wrap
  always_comb begin
    next_dir = dir;
    next_count = counter_value;
    unique case (dir)
      dspwm_pkg::DSPWM_UP: begin
        if (at_top) begin
          next_dir = dspwm_pkg::DSPWM_DOWN;
          next_count = counter_value - 16'h0001;
        end else begin
          next_count = counter_value + 16'h0001;
        end
      end
      dspwm_pkg::DSPWM_DOWN: begin
        if (at_bottom) begin
          next_dir = dspwm_pkg::DSPWM_UP;
          next_count = counter_value + 16'h0001;
        end else begin
          next_count = counter_value - 16'h0001;
        end
      end
    endcase
  end

  // counter and direction advance only on the tick
  // outside modes 8 and 9 the counter freezes where it stands, so a
  // mode change resumes from there; a reset gives a clean start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      counter_value <= dspwm_pkg::WORD_RST;
      dir <= dspwm_pkg::DSPWM_UP;
    end else if (timer_tick && mode_pfc) begin
      counter_value <= next_count;
      dir <= next_dir;
    end
  end

  // active compares reload from buffers at bottom in modes 8 and 9
  // loading at bottom rather than top keeps both slopes of a period
  // on the same compare, which is what keeps the output symmetric
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmp_a <= dspwm_pkg::WORD_RST;
      cmp_b <= dspwm_pkg::WORD_RST;
    end else if (tick_bottom || !mode_pfc) begin
      // outside these modes the buffer passes straight through
      cmp_a <= buf_a;
      cmp_b <= buf_b;
    end
  end

  // software registers; compare writes go to buffers
  // compares written across a bottom may pair old and new values
  // for one period, never inside a single slope
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_a <= dspwm_pkg::CTRL_A_RST;
      ctrl_b <= dspwm_pkg::CTRL_B_RST;
      buf_a <= dspwm_pkg::WORD_RST;
      buf_b <= dspwm_pkg::WORD_RST;
      cap_top <= dspwm_pkg::WORD_RST;
      pin_dir <= 2'h0;
    end else if (wr) begin
      if (paddr == dspwm_pkg::ADDR_CTRL_A) begin
        ctrl_a <= pwdata[7:0] & 8'hF3;  // bits 3:2 stay zero
      end
      if (paddr == dspwm_pkg::ADDR_CTRL_B) begin
        ctrl_b <= pwdata[7:0] & 8'h1F;
      end
      if (paddr == dspwm_pkg::ADDR_CMP_A) begin
        buf_a <= pwdata[15:0];
      end
      if (paddr == dspwm_pkg::ADDR_CMP_B) begin
        buf_b <= pwdata[15:0];
      end
      if (paddr == dspwm_pkg::ADDR_CAP_TOP) begin
        cap_top <= pwdata[15:0];
      end
      if (paddr == dspwm_pkg::ADDR_PINDIR) begin
        pin_dir <= pwdata[1:0];
      end
    end
  end

  // sticky flags, a set in the same cycle as its clear wins
  // losing an event to a racing clear would hide a whole period
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // direction a match is judged by: the top tick already belongs to the
  // falling slope and the bottom tick to the rising one, so a compare at
  // top sets a non-inverted output and one at bottom clears it
  logic slope_down;
  logic slope_up;
  assign slope_down = (next_dir == dspwm_pkg::DSPWM_DOWN);
  assign slope_up = !slope_down;
  // toggle works in modes 8 and 9 only, on channel a only
  logic toggle_a;
  assign toggle_a = (oms_a == dspwm_pkg::OMS_TOGGLE) && mode_dual;

  // wave outputs: clear up / set down, inverted in mode three
  // bottom compare never sets on the way down, so stays low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wave <= 2'h0;
    end else if (timer_tick && mode_pfc) begin
      if (match_a) begin
        if (toggle_a) begin
          wave[0] <= ~wave[0];
        end else if (oms_a == dspwm_pkg::OMS_NONINV) begin
          wave[0] <= slope_down;
        end else if (oms_a == dspwm_pkg::OMS_INV) begin
          wave[0] <= slope_up;
        end
      end
      if (match_b) begin
        if (oms_b == dspwm_pkg::OMS_NONINV) begin
          wave[1] <= slope_down;
        end else if (oms_b == dspwm_pkg::OMS_INV) begin
          wave[1] <= slope_up;
        end
      end
    end
  end

  // a pin is connected only in an output mode that drives it
  logic conn_a;
  logic conn_b;
  assign conn_a = (oms_a != dspwm_pkg::OMS_OFF);
  // toggle setting leaves channel b disconnected
  assign conn_b = (oms_b == dspwm_pkg::OMS_NONINV) ||
    (oms_b == dspwm_pkg::OMS_INV);
  // the pin sees the wave only when its direction bit is output
  assign pin_out = wave;
  assign pin_oe = pin_dir & {conn_b, conn_a};

  // read mux, registered so data comes from flip-flops
  // unmapped addresses fall through to zero, matching the error reply
  logic [31:0] rd_mux;
  assign rd_mux =
    (paddr == dspwm_pkg::ADDR_CTRL_A) ? {24'h00_0000, ctrl_a} :
    (paddr == dspwm_pkg::ADDR_CTRL_B) ? {24'h00_0000, ctrl_b} :
    (paddr == dspwm_pkg::ADDR_CMP_A) ? {16'h0000, buf_a} :
    (paddr == dspwm_pkg::ADDR_CMP_B) ? {16'h0000, buf_b} :
    (paddr == dspwm_pkg::ADDR_CAP_TOP) ? {16'h0000, cap_top} :
    (paddr == dspwm_pkg::ADDR_COUNT) ? {16'h0000, counter_value} :
    (paddr == dspwm_pkg::ADDR_FLAGS) ? {28'h000_0000, flags} :
    (paddr == dspwm_pkg::ADDR_PINDIR) ? {30'h0000_0000, pin_dir} :
    32'h0000_0000;

  // read data captured in the setup cycle, stable through access
  // loading in setup costs nothing here because pready never waits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end
endmodule

//--- test/dspwm_checker.sv
/* dspwm_checker: port assertions for dspwm_core.
   assumes: bound into dspwm_core; pready tied high; one clock. */
`timescale 1ns/1ps
module dspwm_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic timer_tick
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // access phase and address decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit = paddr[1:0] == 2'b00 && paddr <= dspwm_pkg::ADDR_PINDIR;
  logic [2:0] cs; // clock select last written
  logic [1:0] nt; // ticks since it changed, saturating
  logic [9:0] gap; // cycles since the last tick
  // tick spacing counter
  always_ff @(posedge clk_sys) begin
    gap <= (srst || timer_tick) ? 10'h000 : gap + 10'h001;
  end
  // the first ticks after a change may be ragged, so they are skipped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs <= dspwm_pkg::CS_STOP;
      nt <= 2'h0;
    end else if (wr && paddr == dspwm_pkg::ADDR_CTRL_B &&
                 pwdata[2:0] != cs) begin
      cs <= pwdata[2:0];
      nt <= 2'h0;
    end else if (timer_tick && nt != 2'h3) begin
      nt <= nt + 2'h1;
    end
  end
  property p_err_map;
    acc && !hit |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_quiet;
    pslverr |-> acc && !hit;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("stray slave error");
  property p_ctrl_a;
    acc && !pwrite && paddr == dspwm_pkg::ADDR_CTRL_A |->
      prdata[31:8] == 24'h00_0000 && prdata[3:2] == 2'b00;
  endproperty
  a_ctrl_a: assert property (p_ctrl_a) else $error("ctrl a bad bits");
  property p_oe;
    $changed(pin_oe) |-> $past(wr);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved alone");
  property p_out;
    $changed(pin_out) |-> $past(timer_tick) || $past(timer_tick, 2) ||
      $past(wr) || $past(wr, 2);
  endproperty
  a_out: assert property (p_out) else $error("output off tick");
  property p_div1;
    timer_tick && cs == dspwm_pkg::CS_DIV1 && nt[1] |-> gap == 10'h000;
  endproperty
  a_div1: assert property (p_div1) else $error("div1 gap wrong");
  property p_div8;
    timer_tick && cs == dspwm_pkg::CS_DIV8 && nt[1] |-> gap == 10'h007;
  endproperty
  a_div8: assert property (p_div8) else $error("div8 gap wrong");
  property p_stop;
    cs == dspwm_pkg::CS_STOP && $past(cs, 3) == dspwm_pkg::CS_STOP
      |-> !timer_tick;
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  c_err: cover property (acc && !hit);
  c_div8: cover property (timer_tick && cs == dspwm_pkg::CS_DIV8 && nt[1]);
  c_wave: cover property ($changed(pin_out));
endmodule
bind dspwm_core dspwm_checker i_dspwm_checker (.clk_sys, .srst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pin_out, .pin_oe, .timer_tick);

//--- test/dspwm_load.sv
/* dspwm_load: the load on the two wave pins.
   assumes: a pull-down holds a released pin low. */
`timescale 1ns/1ps
module dspwm_load (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] lvl
);
  // the load sees the level only where the pin driver is on
  assign lvl = pin_oe & pin_out;
endmodule

//--- test/dual_slope_freq_correct_pwm_tb_top.sv
/* dual_slope_freq_correct_pwm_tb_top: self-checking bench, dspwm_core.
   assumes: zero wait apb slave; pins feed the load model. */
`timescale 1ns/1ps
module dual_slope_freq_correct_pwm_tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rq, hi, lo, t, ca, cb, n;
  logic pready, pslverr, timer_tick, re, ia, ib;
  logic [1:0] pin_out, pin_oe, lvl;
  int failures = 0;
  int checks_done = 0;
  // 50 mhz system clock
  always #10 clk_sys = ~clk_sys;
  dspwm_core i_dspwm_core (.clk_sys, .srst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_out, .pin_oe,
    .timer_tick);
  dspwm_load i_dspwm_load (.pin_out, .pin_oe, .lvl);
  // divide ratio expected for a clock select
  function automatic logic [31:0] ratio(input int s);
    case (s)
      1: return 32'h0000_0001;
      2: return 32'h0000_0008;
      3: return 32'h0000_0040;
      4: return 32'h0000_0100;
      default: return 32'h0000_0400;
    endcase
  endfunction
  // ticks a pin stays high for compare c under top tt
  function automatic logic [31:0] span(input logic inv,
                                       input logic [31:0] tt, c);
    return 32'h0000_0002 * (inv ? tt - c : c);
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; read data and error land in rq and re
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles up to the next tick, sampled mid-cycle
  task automatic nxt(output logic [31:0] c);
    c = 32'h0000_0000;
    do begin
      @(negedge clk_sys);
      c++;
    end while (timer_tick !== 1'b1);
  endtask
  // ticks of one full high and low span on a pin
  task automatic meas(input int ch);
    hi = 32'h0000_0000;
    lo = 32'h0000_0000;
    @(negedge clk_sys);
    while (lvl[ch] !== 1'b0) @(negedge clk_sys);
    while (lvl[ch] !== 1'b1) @(negedge clk_sys);
    while (lvl[ch] === 1'b1) begin
      hi += {31'h0, timer_tick};
      @(negedge clk_sys);
    end
    while (lvl[ch] === 1'b0) begin
      lo += {31'h0, timer_tick};
      @(negedge clk_sys);
    end
  endtask
  // a fresh start keeps the counter below any new top
  task automatic rst_pulse();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
  endtask
  // bound well beyond the expected run length of about 5000 cycles
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h9c1f));
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    apb(1'b0, dspwm_pkg::ADDR_CTRL_A, 32'h0000_0000);
    chk("ctrl_a_reset", 32'h0000_0000, rq);
    apb(1'b1, dspwm_pkg::ADDR_CTRL_A, 32'hFFFF_FFFF);
    apb(1'b0, dspwm_pkg::ADDR_CTRL_A, 32'h0000_0000);
    chk("ctrl_a_bits", 32'h0000_00F3, rq);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, re});
    $display("register test done");
    for (int s = 1; s <= 5; s++) begin
      apb(1'b1, dspwm_pkg::ADDR_CTRL_B, 32'(s));
      nxt(n);
      nxt(n);
      nxt(n);
      chk("tick_gap", ratio(s), n);
    end
    $display("prescaler test done");
    for (int k = 0; k < 3; k++) begin
      rst_pulse();
      t = 3 + $urandom % 14; // top never below three
      ca = 1 + $urandom % (t - 1); // compares under top
      cb = 1 + $urandom % (t - 1);
      apb(1'b1, dspwm_pkg::ADDR_CAP_TOP, t); // fixed top
      apb(1'b1, dspwm_pkg::ADDR_CMP_A, ca);
      apb(1'b1, dspwm_pkg::ADDR_CMP_B, cb);
      ia = 1'($urandom % 2); // random polarity per channel
      ib = 1'($urandom % 2);
      apb(1'b1, dspwm_pkg::ADDR_CTRL_A, {24'h00_0000, 1'b1, ia, 1'b1, ib,
                                         4'h0});
      apb(1'b1, dspwm_pkg::ADDR_CTRL_B, 32'h0000_0011);
      apb(1'b1, dspwm_pkg::ADDR_PINDIR, 32'h0000_0003);
      meas(0);
      chk("a_high", span(ia, t, ca), hi);
      chk("a_low", span(~ia, t, ca), lo);
      meas(1);
      chk("b_high", span(ib, t, cb), hi);
      chk("b_low", span(~ib, t, cb), lo);
      apb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0000_0000);
      chk("flags_set", 32'h0000_000F, rq);
      apb(1'b1, dspwm_pkg::ADDR_CTRL_B, 32'h0000_0010);
      apb(1'b1, dspwm_pkg::ADDR_FLAGS, 32'h0000_000F);
      apb(1'b0, dspwm_pkg::ADDR_FLAGS, 32'h0000_0000);
      chk("flags_clear", 32'h0000_0000, rq);
    end
    $display("pwm test done");
    rst_pulse();
    t = 3 + $urandom % 14; // top from compare a
    apb(1'b1, dspwm_pkg::ADDR_CMP_A, t);
    apb(1'b1, dspwm_pkg::ADDR_CTRL_A, 32'h0000_0051);
    apb(1'b1, dspwm_pkg::ADDR_CTRL_B, 32'h0000_0011);
    apb(1'b1, dspwm_pkg::ADDR_PINDIR, 32'h0000_0003);
    meas(0);
    chk("toggle_high", 32'h0000_0002 * t, hi);
    chk("toggle_low", 32'h0000_0002 * t, lo);
    chk("toggle_oe", 32'h0000_0001, {30'h0, pin_oe});
    $display("toggle test done");
    rst_pulse();
    t = 3 + $urandom % 14;
    apb(1'b1, dspwm_pkg::ADDR_CAP_TOP, t);
    apb(1'b1, dspwm_pkg::ADDR_CMP_A, 32'h0000_0000);
    apb(1'b1, dspwm_pkg::ADDR_CMP_B, t);
    apb(1'b1, dspwm_pkg::ADDR_CTRL_A, 32'h0000_00A0);
    apb(1'b1, dspwm_pkg::ADDR_CTRL_B, 32'h0000_0011);
    chk("pins_input", 32'h0000_0000, {30'h0, pin_oe});
    apb(1'b1, dspwm_pkg::ADDR_PINDIR, 32'h0000_0003);
    repeat (4 * t) nxt(n);
    for (int i = 0; i < 4 * t; i++) begin
      nxt(n);
      chk("extreme_lvl", 32'h0000_0002, {30'h0, lvl});
    end
    $display("extreme test done");
    finish_test();
  end
endmodule
